/* File: src/uisc_top.sv */
// Interrupt status and clear register of the UART bridge
//
// Summary of operation
// - Status register reachable only with control reg at BF and SPECIAL_FUNCTION_REG bit2 set.
// - Reset clears the status register to zero.
// - Bit 7 reads one while CTS/RTS change interrupt is active.
// - Bit 6 reads one while Xoff or special character interrupt is active.
// - Bit 5 reads one while modem status interrupt is active.
// - Bit 4 reads one while transmit holding interrupt is active.
// - Bit 3 reads one while receiver timeout interrupt is active.
// - Bit 2 reads one while receive holding interrupt is active.
// - Bit 1 reads one while receive line error interrupt is active.
// - Writing one to bit 0 clears all status flags, except those whose source is active in the same cycle.
// - Clear command bit self-clears and always reads zero.
// - SPECIAL_FUNCTION_REG bit 2 enables access to the special register group.
`timescale 1ns/100ps
module uisc_top
  import uisc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire uisc_req_type req_i,
  input  wire uisc_src_type src_i,
  input  wire uisc_src_type serviced_i,
  output logic [7:0]        rdata_o,
  output logic              rvalid_o,
  output logic              clear_pulse_o,
  output logic [7:0]        status_o
);

  // ----------------------------------------------------------------
  // Gate registers
  // ----------------------------------------------------------------
  logic [7:0] lcr_ff;
  logic [7:0] sfr_ff;
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic       spec_en;
  logic       interrupt_status_clear_hit;
  logic       clr_cmd;

  assign spec_en  = (lcr_ff == UISC_LCR_ENABLE)
                    && sfr_ff[UISC_SFR_SPEN_BIT];
  assign interrupt_status_clear_hit = spec_en && (req_i.addr == UISC_ADDR_INTERRUPT_STATUS_CLEAR);
  assign clr_cmd  = interrupt_status_clear_hit && req_i.wr
                    && req_i.wdata[UISC_BIT_CLEAR];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lcr_ff <= UISC_LCR_RESET;
    end else if (req_i.wr && req_i.addr == UISC_ADDR_LCR) begin
      lcr_ff <= req_i.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sfr_ff <= UISC_SFR_RESET;
    end else if (req_i.wr && req_i.addr == UISC_ADDR_SFR
                 && lcr_ff == UISC_LCR_ENABLE) begin
      sfr_ff <= req_i.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_comb begin
    nxt_flags = flags_ff;
    if (clr_cmd) begin
      nxt_flags = 8'h00;
    end else if (interrupt_status_clear_hit && req_i.wr) begin
      nxt_flags = req_i.wdata;
    end
    nxt_flags[7:1] = nxt_flags[7:1] & ~serviced_i;
    nxt_flags[7:1] = nxt_flags[7:1] | src_i;
    nxt_flags[UISC_BIT_CLEAR] = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flags_ff <= UISC_INTERRUPT_STATUS_CLEAR_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      if (req_i.rd && interrupt_status_clear_hit) begin
        rdata_o <= flags_ff;
      end else if (req_i.rd && req_i.addr == UISC_ADDR_SFR
                   && lcr_ff == UISC_LCR_ENABLE) begin
        rdata_o <= sfr_ff;
      end else if (req_i.rd && req_i.addr == UISC_ADDR_LCR) begin
        rdata_o <= lcr_ff;
      end else if (req_i.rd) begin
        rdata_o <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      clear_pulse_o <= 1'b0;
    end else begin
      clear_pulse_o <= clr_cmd;
    end
  end

  assign status_o = flags_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_zero;
    @(posedge clk_i) !rst_b_i |=> flags_ff == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("status not zero after reset");

  property p_bit0_zero;
    @(posedge clk_i) disable iff (!rst_b_i) flags_ff[0] == 1'b0;
  endproperty
  a_bit0_zero: assert property (p_bit0_zero)
    else $error("clear bit read as set");

  property p_clear_all;
    @(posedge clk_i) disable iff (!rst_b_i)
      clr_cmd && src_i == '0 |=> flags_ff == 8'h00;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("clear command left flags set");

  property p_gate;
    @(posedge clk_i) disable iff (!rst_b_i)
      req_i.wr && req_i.addr == UISC_ADDR_INTERRUPT_STATUS_CLEAR && !spec_en
      && src_i == '0 && serviced_i == '0 |=> $stable(flags_ff);
  endproperty
  a_gate: assert property (p_gate)
    else $error("status written while access closed");

  property p_flow;
    @(posedge clk_i) disable iff (!rst_b_i)
      src_i.flow_change |=> flags_ff[UISC_BIT_FLOW];
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow change flag not set");

  property p_xoff;
    @(posedge clk_i) disable iff (!rst_b_i)
      src_i.xoff_special |=> flags_ff[UISC_BIT_XOFF];
  endproperty
  a_xoff: assert property (p_xoff)
    else $error("xoff flag not set");

  property p_lerr;
    @(posedge clk_i) disable iff (!rst_b_i)
      src_i.line_error |=> flags_ff[UISC_BIT_LERR];
  endproperty
  a_lerr: assert property (p_lerr)
    else $error("line error flag not set");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      flags_ff[UISC_BIT_RTO] && !serviced_i.rx_timeout
      && !(interrupt_status_clear_hit && req_i.wr) |=> flags_ff[UISC_BIT_RTO];
  endproperty
  a_hold: assert property (p_hold)
    else $error("timeout flag dropped without cause");

  property p_read;
    @(posedge clk_i) disable iff (!rst_b_i)
      req_i.rd && interrupt_status_clear_hit |=> rvalid_o && rdata_o == $past(flags_ff);
  endproperty
  a_read: assert property (p_read)
    else $error("status read returned wrong value");

endmodule

/* File: src/uisc_pkg.sv */
// Package with register map, field positions and carrier types
package uisc_pkg;

  localparam logic [7:0] UISC_ADDR_INTERRUPT_STATUS_CLEAR    = 8'h0F;
  localparam logic [7:0] UISC_ADDR_SFR     = 8'h07;
  localparam logic [7:0] UISC_ADDR_LCR     = 8'h03;
  localparam logic [7:0] UISC_LCR_ENABLE   = 8'hBF;
  localparam int         UISC_SFR_SPEN_BIT = 2;
  localparam logic [7:0] UISC_INTERRUPT_STATUS_CLEAR_RESET   = 8'h00;
  localparam logic [7:0] UISC_SFR_RESET    = 8'h00;
  localparam logic [7:0] UISC_LCR_RESET    = 8'h00;

  localparam int UISC_BIT_CLEAR = 0;
  localparam int UISC_BIT_LERR  = 1;
  localparam int UISC_BIT_RXH   = 2;
  localparam int UISC_BIT_RTO   = 3;
  localparam int UISC_BIT_TXH   = 4;
  localparam int UISC_BIT_MODEM = 5;
  localparam int UISC_BIT_XOFF  = 6;
  localparam int UISC_BIT_FLOW  = 7;

  // Interrupt sources, one bit per flag 7..1
  typedef struct packed {
    logic flow_change;
    logic xoff_special;
    logic modem;
    logic transmit_holding;
    logic rx_timeout;
    logic receive_holding;
    logic line_error;
  } uisc_src_type;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } uisc_req_type;

endpackage

/* File: verification/uisc_host_model.sv */
// Host model issuing register accesses to the status block
`timescale 1ns/100ps
module uisc_host_model
  import uisc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic [7:0]   rdata_i,
  output uisc_req_type      req_o
);
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  initial req_o = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 req_o = {1'b1, 1'b0, a, d};
    @(posedge clk_i);
    #1 req_o = '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1 req_o = {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    #1 req_o = '0;
    d = rdata_i;
  endtask
endmodule

/* File: verification/tb_top.sv */
// Testbench for the interrupt status and clear register
`timescale 1ns/100ps
module tb_top;
  import uisc_pkg::*;
  logic         clk_i;
  logic         rst_b_i;
  uisc_src_type src;
  uisc_src_type svc;
  uisc_req_type req;
  logic [7:0]   rdata;
  logic [7:0]   status;
  logic [7:0]   d;
  logic         rvalid;
  logic         clr;
  int           error_cnt;
  int           checks;
  int           cyc;

  uisc_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req),
    .src_i(src), .serviced_i(svc), .rdata_o(rdata), .rvalid_o(rvalid),
    .clear_pulse_o(clr), .status_o(status));
  uisc_host_model host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));

  // ----------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic pulse(input logic s, input logic [6:0] v);
    @(posedge clk_i);
    #1;
    if (s) src = v;
    else svc = v;
    @(posedge clk_i);
    #1 src = '0;
    svc = '0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b_i = 1'b0;
    src = '0;
    svc = '0;
    error_cnt = 0;
    checks = 0;
    cyc = 0;
    repeat (10) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    chk(status, UISC_INTERRUPT_STATUS_CLEAR_RESET);
    pulse(1'b1, 7'h01);
    host.rd(UISC_ADDR_INTERRUPT_STATUS_CLEAR, d);
    chk(d, 8'h00);
    host.wr(UISC_ADDR_INTERRUPT_STATUS_CLEAR, 8'h01);
    chk(status, 8'h02);
    pulse(1'b0, 7'h01);
    chk(status, 8'h00);
    host.wr(UISC_ADDR_LCR, UISC_LCR_ENABLE);
    host.wr(UISC_ADDR_SFR, 8'h04);
    for (int i = 1; i < 8; i++) begin
      pulse(1'b1, 7'h01 << (i - 1));
      host.rd(UISC_ADDR_INTERRUPT_STATUS_CLEAR, d);
      chk(d, 8'h01 << i);
      chk({7'h00, rvalid}, 8'h01);
      pulse(1'b0, 7'h01 << (i - 1));
      chk(status, 8'h00);
    end
    pulse(1'b1, 7'h7F);
    chk(status, 8'hFE);
    host.wr(UISC_ADDR_INTERRUPT_STATUS_CLEAR, 8'h01);
    chk(status, 8'h00);
    chk({7'h00, clr}, 8'h01);
    host.rd(UISC_ADDR_INTERRUPT_STATUS_CLEAR, d);
    chk(d, 8'h00);
    pulse(1'b1, 7'h10);
    host.wr(UISC_ADDR_SFR, 8'h00);
    host.rd(UISC_ADDR_INTERRUPT_STATUS_CLEAR, d);
    chk(d, 8'h00);
    chk(status, 8'h20);
    results();
  end
endmodule
